// ==== hw/nvcl_map.vh ====
// Constants for the nonvolatile configuration latch block
`ifndef NVCL_MAP_VH
`define NVCL_MAP_VH
// ----------------------------------------
// Byte addresses of configuration latch
// ----------------------------------------
`define NVCL_PORT_DRIVE_MODE_LOW 2'h0
`define NVCL_PORT_DRIVE_MODE_HIGH 2'h1
`define NVCL_RESET_PIN_DEBUG_CONFIG 2'h2
`define NVCL_CLOCK_ECC_PORT_CONFIG 2'h3
// ----------------------------------------
// Array select in address byte bit 7
// ----------------------------------------
`define NVCL_ARRAY_SEL_BIT 7
// ----------------------------------------
// Field positions
// ----------------------------------------
`define NVCL_EXT_RESET_BIT 7
`define NVCL_DEBUG_EN_BIT 6
`define NVCL_BOOT_SPEED_BIT 0
`define NVCL_DPS_LSB 1
`define NVCL_ECC_BIT 3
`define NVCL_PHS_LSB 4
// ----------------------------------------
// Command codes
// ----------------------------------------
`define NVCL_CMD_LOAD_BYTE 8'h00
`define NVCL_CMD_READ_BYTE 8'h10
`define NVCL_CMD_WRITE_NVL 8'h06
`define NVCL_CMD_READ_NVL 8'h03
// ----------------------------------------
// Field encodings and key
// ----------------------------------------
`define NVCL_DPS_NONE 2'h3
`define NVCL_PHS_MAX 4'hB
`define NVCL_KEY_MIN_MATCH 6'h1C
`define NVCL_RESET_VALUE 8'h00
`endif

// ==== hw/nvcl_key_match.v ====
// Super-majority key match of the write-once latch
`timescale 1ns/1ps
module nvcl_key_match #(
   parameter [31:0] KEY = 32'h5A5A5A5A // Arbitrary value
) (
   // Latch contents
   input wire [31:0] value,
   // Match result
   output reg match
);
`include "nvcl_map.vh"
   reg [5:0] count;
   integer i;
   always @* begin
      count = 6'h00;
      for (i = 0; i < 32; i = i + 1) begin
         count = count + {5'h00, ~(value[i] ^ KEY[i])};
      end
      match = (count >= `NVCL_KEY_MIN_MATCH);
   end
endmodule // nvcl_key_match

// ==== hw/nvcl_latch.v ====
// Nonvolatile configuration and write-once security latches
//
// Contract
// - Load nonvolatile cells into latches at reset
// - Four config bytes plus four write-once bytes
// - Two-bit fields select port reset drive
// - Reset pin select: GPIO or external reset
// - Debug enable bypasses test acquire
// - Boot speed bit: 12 or 48 MHz
// - No port: only test acquire activates one
// - Correction enable bit turns flash ECC on
// - Phase delay codes, invalid ones disable clock
// - Key matches when 28 of 32 bits agree
// - Locked: block debug, refuse write-once changes
// - Lock sampled only at reset
// - Key write only without flash protection
// - Write-once contents readable over debug wire
// - Bytes in and answers out same port
// - Command 0x00 loads a volatile byte
// - Command 0x10 reads a volatile byte
// - Command 0x06 programs array nonvolatile cells
// - Command 0x03 reads and reloads array
// - Sleep rejects access, outputs stay stable
`timescale 1ns/1ps
module nvcl_latch (
   // Clock and power-on reset
   input wire clk,
   input wire rst,
   // Power state and protection status
   input wire sleep,
   input wire flash_protect_set,
   input wire test_acquired,
   // CPU command data port
   input wire cpu_wr,
   input wire [7:0] cpu_wdata,
   input wire cpu_rd,
   output reg [7:0] cpu_rdata,
   output reg cpu_rvalid,
   // DMA command data port
   input wire dma_wr,
   input wire [7:0] dma_wdata,
   input wire dma_rd,
   output reg [7:0] dma_rdata,
   output reg dma_rvalid,
   // Single-wire debug read of the write-once latch
   input wire [1:0] swd_wol_addr,
   output reg [7:0] swd_wol_data,
   // Configuration outputs
   output reg [15:0] port_reset_drive_mode,
   output reg [1:0] port15_reset_drive_mode,
   output reg ext_reset_pin_select,
   output reg boot_osc_speed,
   output reg [1:0] debug_port_select,
   output reg flash_correction_enable,
   output reg [3:0] digital_clock_phase_delay,
   output reg digital_clock_enable,
   output reg debug_access_enable,
   output reg debug_port_active,
   output reg security_locked,
   output reg busy
);
`include "nvcl_map.vh"
   // ----------------------------------------
   // State and storage
   // ----------------------------------------
   localparam [2:0] ST_LOAD = 3'h0;
   localparam [2:0] ST_IDLE = 3'h1;
   localparam [2:0] ST_ADDR = 3'h2;
   localparam [2:0] ST_DATA = 3'h3;
   localparam [2:0] ST_EXEC = 3'h4;

   reg [7:0] cfg_nv [0:3];
   reg [7:0] cfg_vol [0:3];
   reg [7:0] wol_nv [0:3];
   reg [7:0] wol_vol [0:3];
   reg [2:0] state;
   reg [7:0] cmd;
   reg [7:0] addr;
   reg [7:0] wdata;
   reg src_dma;
   integer k;

   wire in_wr = cpu_wr | dma_wr;
   wire [7:0] in_byte = cpu_wr ? cpu_wdata : dma_wdata;
   wire sel_wol = addr[`NVCL_ARRAY_SEL_BIT];
   wire [1:0] idx = addr[1:0];
   wire key_match;

   nvcl_key_match u_match (
      .value({wol_nv[3], wol_nv[2], wol_nv[1], wol_nv[0]}),
      .match(key_match)
   );

   function needs_addr;
      input [7:0] c;
      begin
         needs_addr = (c == `NVCL_CMD_LOAD_BYTE) || (c == `NVCL_CMD_READ_BYTE) ||
            (c == `NVCL_CMD_READ_NVL);
      end
   endfunction

   // Wol changes refused when locked or when protected, for volatile loads and programming alike
   function wol_blocked;
      input dummy;
      begin
         wol_blocked = security_locked | flash_protect_set;
      end
   endfunction

   // ----------------------------------------
   // Command engine
   // ----------------------------------------
   always @(posedge clk) begin
      if (rst) begin
         state <= ST_LOAD;
         cmd <= 8'h00;
         addr <= 8'h00;
         wdata <= 8'h00;
         src_dma <= 1'b0;
         cpu_rdata <= 8'h00;
         cpu_rvalid <= 1'b0;
         dma_rdata <= 8'h00;
         dma_rvalid <= 1'b0;
         busy <= 1'b1;
         for (k = 0; k < 4; k = k + 1) begin
            cfg_vol[k] <= `NVCL_RESET_VALUE;
            wol_vol[k] <= `NVCL_RESET_VALUE;
         end
      end else begin
         cpu_rvalid <= 1'b0;
         dma_rvalid <= 1'b0;
         case (state)
            ST_LOAD: begin
               for (k = 0; k < 4; k = k + 1) begin
                  cfg_vol[k] <= cfg_nv[k];
                  wol_vol[k] <= wol_nv[k];
               end
               busy <= 1'b0;
               state <= ST_IDLE;
            end
            ST_IDLE: begin
               if (in_wr && !sleep) begin
                  cmd <= in_byte;
                  src_dma <= !cpu_wr;
                  if (needs_addr(in_byte)) begin
                     state <= ST_ADDR;
                  end else if (in_byte == `NVCL_CMD_WRITE_NVL) begin
                     state <= ST_ADDR;
                  end else begin
                     state <= ST_IDLE;
                  end
               end
            end
            ST_ADDR: begin
               if (in_wr && !sleep && (cpu_wr ^ src_dma)) begin
                  addr <= in_byte;
                  state <= (cmd == `NVCL_CMD_LOAD_BYTE) ? ST_DATA : ST_EXEC;
                  busy <= (cmd != `NVCL_CMD_LOAD_BYTE);
               end
            end
            ST_DATA: begin
               if (in_wr && !sleep && (cpu_wr ^ src_dma)) begin
                  wdata <= in_byte;
                  busy <= 1'b1;
                  state <= ST_EXEC;
               end
            end
            ST_EXEC: begin
               busy <= 1'b0;
               state <= ST_IDLE;
               case (cmd)
                  `NVCL_CMD_LOAD_BYTE: begin
                     if (!sel_wol) begin
                        cfg_vol[idx] <= wdata;
                     end else if (!wol_blocked(1'b0)) begin
                        wol_vol[idx] <= wdata;
                     end
                  end
                  `NVCL_CMD_READ_BYTE: begin
                     cpu_rdata <= sel_wol ? wol_vol[idx] : cfg_vol[idx];
                     dma_rdata <= sel_wol ? wol_vol[idx] : cfg_vol[idx];
                     cpu_rvalid <= !src_dma;
                     dma_rvalid <= src_dma;
                  end
                  `NVCL_CMD_READ_NVL: begin
                     cpu_rdata <= sel_wol ? wol_nv[idx] : cfg_nv[idx];
                     dma_rdata <= sel_wol ? wol_nv[idx] : cfg_nv[idx];
                     cpu_rvalid <= !src_dma;
                     dma_rvalid <= src_dma;
                     for (k = 0; k < 4; k = k + 1) begin
                        if (sel_wol) begin
                           if (!security_locked) begin
                              wol_vol[k] <= wol_nv[k];
                           end
                        end else begin
                           cfg_vol[k] <= cfg_nv[k];
                        end
                     end
                  end
                  default: begin
                  end
               endcase
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Nonvolatile cells, kept across reset
   // ----------------------------------------
   // Cells start erased so the lock never sees unknown bits
   initial begin
      for (k = 0; k < 4; k = k + 1) begin
         cfg_nv[k] = `NVCL_RESET_VALUE;
         wol_nv[k] = `NVCL_RESET_VALUE;
      end
   end

   always @(posedge clk) begin
      if (!rst && state == ST_EXEC && cmd == `NVCL_CMD_WRITE_NVL) begin
         for (k = 0; k < 4; k = k + 1) begin
            if (!sel_wol) begin
               cfg_nv[k] <= cfg_vol[k];
            end else if (!wol_blocked(1'b0)) begin
               wol_nv[k] <= wol_vol[k];
            end
         end
      end
   end

   // ----------------------------------------
   // Configuration outputs from volatile latches
   // ----------------------------------------
   always @(posedge clk) begin
      if (rst) begin
         port_reset_drive_mode <= 16'h0000;
         port15_reset_drive_mode <= 2'h0;
         ext_reset_pin_select <= 1'b0;
         boot_osc_speed <= 1'b0;
         debug_port_select <= `NVCL_DPS_NONE;
         flash_correction_enable <= 1'b0;
         digital_clock_phase_delay <= 4'h0;
         digital_clock_enable <= 1'b0;
         debug_access_enable <= 1'b0;
         debug_port_active <= 1'b0;
         swd_wol_data <= 8'h00;
      end else if (!sleep) begin
         port_reset_drive_mode <= {cfg_vol[1], cfg_vol[0]};
         port15_reset_drive_mode <= cfg_vol[2][1:0];
         ext_reset_pin_select <= cfg_vol[2][`NVCL_EXT_RESET_BIT];
         boot_osc_speed <= cfg_vol[3][`NVCL_BOOT_SPEED_BIT];
         debug_port_select <= cfg_vol[3][`NVCL_DPS_LSB +: 2];
         flash_correction_enable <= cfg_vol[3][`NVCL_ECC_BIT];
         digital_clock_phase_delay <= cfg_vol[3][`NVCL_PHS_LSB +: 4];
         digital_clock_enable <= (cfg_vol[3][`NVCL_PHS_LSB +: 4] != 4'h0) &&
            (cfg_vol[3][`NVCL_PHS_LSB +: 4] <= `NVCL_PHS_MAX);
         debug_access_enable <= !security_locked &&
            (cfg_vol[2][`NVCL_DEBUG_EN_BIT] || test_acquired);
         debug_port_active <= !security_locked &&
            ((cfg_vol[3][`NVCL_DPS_LSB +: 2] != `NVCL_DPS_NONE) || test_acquired);
         swd_wol_data <= wol_vol[swd_wol_addr];
      end
   end

   // ----------------------------------------
   // Lock sampled only while reset is held
   // ----------------------------------------
   always @(posedge clk) begin
      if (rst) begin
         security_locked <= key_match;
      end
   end
endmodule // nvcl_latch

// ==== verif/nvcl_latch_props.sv ====
// Port assertions for the configuration latch block
`timescale 1ns/1ps
module nvcl_latch_props (
   // Clock and reset
   input wire clk,
   input wire rst,
   // Control and command port
   input wire sleep,
   input wire test_acquired,
   input wire cpu_wr,
   input wire [7:0] cpu_wdata,
   input wire cpu_rvalid,
   input wire dma_rvalid,
   input wire busy,
   // Configuration outputs
   input wire [15:0] port_reset_drive_mode,
   input wire [1:0] debug_port_select,
   input wire [3:0] digital_clock_phase_delay,
   input wire digital_clock_enable,
   input wire debug_access_enable,
   input wire debug_port_active,
   input wire security_locked
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   a_answer_pulse: assert property (cpu_rvalid |=> !cpu_rvalid) else $error("long answer");
   a_read_timing: assert property (
      !cpu_wr ##1 cpu_wr && cpu_wdata == 8'h10 && !busy && !sleep ##1 cpu_wr && !sleep |-> ##2 cpu_rvalid)
      else $error("late read answer");
   a_lock_hold: assert property (!$past(rst) |-> $stable(security_locked)) else $error("lock moved");
   a_lock_debug: assert property (
      security_locked |-> !debug_access_enable && !debug_port_active) else $error("open while locked");
   a_phase_enable: assert property (
      digital_clock_enable == (digital_clock_phase_delay inside {[1:11]})) else $error("clock enable");
   a_no_port: assert property (
      debug_port_select == 2'h3 && !test_acquired && !$past(test_acquired) |-> !debug_port_active)
      else $error("port active");
   a_sleep_freeze: assert property (
      sleep && $past(sleep) && !$past(rst) && !$past(rst, 2)
      |-> $stable(port_reset_drive_mode) && $stable(digital_clock_phase_delay)) else $error("moved in sleep");
   a_sleep_quiet: assert property (sleep [*4] |-> !cpu_rvalid && !dma_rvalid) else $error("sleep answer");
endmodule // nvcl_latch_props
bind nvcl_latch nvcl_latch_props chk_u (.*);

// ==== verif/nvcl_host.sv ====
// Command master on the CPU and DMA data ports
`timescale 1ns/1ps
module nvcl_host (
   // Clock and status
   input wire clk,
   input wire busy,
   // CPU port
   output logic cpu_wr = 1'b0,
   output logic [7:0] cpu_wdata = 8'hA5,
   input wire [7:0] cpu_rdata,
   input wire cpu_rvalid,
   // DMA port
   output logic dma_wr = 1'b0,
   output logic [7:0] dma_wdata = 8'h5A,
   input wire [7:0] dma_rdata,
   input wire dma_rvalid
);
   // Bytes back to back on one port, answer taken from that port
   task automatic xfer(input bit p, input logic [7:0] c, a, d, input int n, output logic [7:0] r);
      logic [7:0] b[3];
      int k;
      b = '{c, a, d};
      for (k = 0; k < n; k++) begin
         @(posedge clk);
         cpu_wr <= !p;
         dma_wr <= p;
         if (p) dma_wdata <= b[k];
         else cpu_wdata <= b[k];
      end
      @(posedge clk);
      cpu_wr <= 1'b0;
      dma_wr <= 1'b0;
      cpu_wdata <= ~cpu_wdata;
      dma_wdata <= ~dma_wdata;
      for (k = 0; k < 200; k++) begin
         #1;
         if (c == 8'h10 || c == 8'h03 ? (p ? dma_rvalid : cpu_rvalid) : !busy) break;
         @(posedge clk);
      end
      r = k < 200 ? (p ? dma_rdata : cpu_rdata) : 8'hxx;
   endtask
endmodule // nvcl_host

// ==== verif/tb.sv ====
// Self-checking bench for the configuration latch block
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; $display("unexpected %0t %h %h", $time, g, e); end end
module tb;
   localparam logic [7:0] KEY = 8'h5A; // Arbitrary key byte, as set in the design
   logic clk = 0, rst = 1, sleep = 0, flash_protect_set = 0, test_acquired = 0, cpu_rd = 0, dma_rd = 0;
   logic [1:0] swd_wol_addr = 0;
   wire cpu_wr, dma_wr, cpu_rvalid, dma_rvalid, ext_reset_pin_select, boot_osc_speed, busy;
   wire flash_correction_enable, digital_clock_enable, debug_access_enable, debug_port_active, security_locked;
   wire [7:0] cpu_wdata, dma_wdata, cpu_rdata, dma_rdata, swd_wol_data;
   wire [15:0] port_reset_drive_mode;
   wire [1:0] port15_reset_drive_mode, debug_port_select;
   wire [3:0] digital_clock_phase_delay;
   logic [7:0] vol[8], nv[8] = '{default: 8'h00}, b;
   bit lkm;
   int n_mismatch = 0, cmp_count = 0, j, k;
   nvcl_latch dut_u (.*);
   nvcl_host host_u (.*);
   initial forever #2 clk = ~clk;
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic op(input bit p, input logic [7:0] c, a, d);
      logic [7:0] r;
      int i;
      bit w;
      i = {a[7], a[1:0]};
      host_u.xfer(p, c, a, d, c == 8'h00 ? 3 : c == 8'h55 ? 1 : 2, r);
      `CHK(r !== 8'hxx, 1'b1)
      w = !sleep && !(a[7] && (lkm || flash_protect_set));
      if (c == 8'h00 && w) vol[i] = d;
      if (c == 8'h10) `CHK(r, vol[i])
      if (c == 8'h03) `CHK(r, nv[i])
      for (int m = 0; m < 4; m++) begin
         if (c == 8'h06 && w) nv[i & 4 | m] = vol[i & 4 | m];
         if (c == 8'h03 && !(a[7] && lkm)) vol[i & 4 | m] = nv[i & 4 | m];
      end
   endtask
   task automatic do_reset(input bit chk);
      int m;
      m = 0;
      @(posedge clk);
      rst <= 1;
      repeat (2) @(posedge clk);
      rst <= 0;
      for (int i = 4; i < 8; i++) m += $countones(~(nv[i] ^ KEY));
      lkm = m >= 28;
      vol = nv;
      repeat (3) @(posedge clk);
      #1;
      if (chk) begin
         `CHK(port_reset_drive_mode, {nv[1], nv[0]})
         `CHK(port15_reset_drive_mode, nv[2][1:0])
         `CHK(ext_reset_pin_select, nv[2][7])
         `CHK(boot_osc_speed, nv[3][0])
         `CHK(debug_port_select, nv[3][2:1])
         `CHK(flash_correction_enable, nv[3][3])
         `CHK(digital_clock_phase_delay, nv[3][7:4])
         `CHK(digital_clock_enable, nv[3][7:4] inside {[1:11]})
         `CHK(security_locked, lkm)
         `CHK(debug_access_enable, !lkm && (nv[2][6] || test_acquired))
         `CHK(debug_port_active, !lkm && (nv[3][2:1] != 2'h3 || test_acquired))
         for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            swd_wol_addr <= 2'(i);
            repeat (2) @(posedge clk);
            #1;
            `CHK(swd_wol_data, vol[4 + i])
         end
      end
   endtask
   initial begin
      #100000;
      n_mismatch++;
      close_out();
   end
   initial begin
      void'($urandom(32'hE196CB3F));
      do_reset(0);
      for (j = 0; j < 4; j++) op(1, 8'h00, 8'(j) | 8'h80, 8'h00);
      op(0, 8'h06, 8'h80, 0);
      // Images cover every port select and phase codes 0, 5, A, F
      for (k = 0; k < 4; k++) begin
         @(posedge clk);
         test_acquired <= k[0] ^ k[1];
         for (j = 0; j < 4; j++) begin
            b = $urandom;
            if (j == 3) b = {4'(k * 5), b[3], k[1:0], b[0]};
            op(j[0], 8'h00, 8'(j), b);
         end
         op(0, 8'h06, 8'h00, 0);
         op(1, 8'h00, 8'h01, ~vol[1]);
         op(1, 8'h03, 8'h00, 0);
         op(0, 8'h55, 8'h00, 0);
         for (j = 0; j < 4; j++) op(j[0], 8'h10, 8'(j), 0);
         do_reset(1);
      end
      @(posedge clk);
      sleep <= 1;
      op(0, 8'h00, 8'h00, 8'hC3);
      @(posedge clk);
      sleep <= 0;
      op(0, 8'h10, 8'h00, 0);
      // Five bits off the key, then four
      for (k = 0; k < 2; k++) begin
         for (j = 0; j < 4; j++) op(0, 8'h00, 8'(j) | 8'h80, j ? KEY : KEY ^ (k ? 8'h0F : 8'h1F));
         @(posedge clk);
         flash_protect_set <= 1;
         op(1, 8'h00, 8'h81, 8'h00);
         @(posedge clk);
         flash_protect_set <= 0;
         op(1, 8'h06, 8'h80, 0);
         `CHK(security_locked, lkm)
         do_reset(1);
      end
      op(0, 8'h00, 8'h82, 8'h00);
      op(0, 8'h06, 8'h80, 0);
      op(1, 8'h03, 8'h82, 0);
      op(0, 8'h10, 8'h82, 0);
      close_out();
   end
endmodule // tb
